// ### ccm_pkg.sv
/*
 * Constants, types and carriers shared by the configuration checker.
 * Assumes one clock and a synchronous active-high reset in every user.
 */
package ccm_pkg;

	// ==========================================================
	// Widths.
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned LEN_W = 12;
	localparam int unsigned NTERM = 128;

	// ==========================================================
	// User parameter block byte indexes and bit positions.
	localparam logic [5:0] PRM_CHK_BYTE = 6'h01;
	localparam int unsigned PRM_CHK_BIT = 0;
	localparam logic [5:0] PRM_MULTI_BYTE = 6'h03;
	localparam int unsigned PRM_MULTI_BIT = 4;
	localparam int unsigned PRM_FORCE_BIT = 6;
	localparam logic [5:0] PRM_MAP_BYTE = 6'h09;
	localparam int unsigned PRM_MAP_BIT = 2;
	localparam logic [5:0] PRM_LO_FIRST = 6'h0f;
	localparam logic [5:0] PRM_LO_LAST = 6'h1e;
	localparam logic [5:0] PRM_HI_FIRST = 6'h29;
	localparam logic [5:0] PRM_HI_LAST = 6'h38;
	localparam logic [6:0] TERM_HI_BASE = 7'h40;
	localparam int unsigned TERM_PER_BYTE = 4;

	// Two-bit terminal assignment codes.
	localparam logic [1:0] TERM_ENABLED = 2'h0;
	localparam logic [1:0] TERM_DISABLED = 2'h2;

	// ==========================================================
	// Slave layout block identifier byte fields.
	localparam int unsigned LAY_LEN_LSB = 0;
	localparam int unsigned LAY_IN_BIT = 4;
	localparam int unsigned LAY_OUT_BIT = 5;
	localparam int unsigned LAY_WORD_BIT = 6;

	// Control and status bytes added per analog module in complex form.
	localparam logic [4:0] CTL_BYTES = 5'h01;

	// ==========================================================
	// Register word indexes.
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h1;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h2;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h3;
	localparam logic [ADDR_W-1:0] REG_IN_LEN = 4'h4;
	localparam logic [ADDR_W-1:0] REG_OUT_LEN = 4'h5;
	localparam logic [ADDR_W-1:0] REG_DIG_OFF = 4'h6;

	// Control register bit, reset value zero (compact).
	localparam int unsigned CTRL_CPLX_BIT = 0;

	// Interrupt sources, one bit each.
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_PRM = 0;
	localparam int unsigned IRQ_LAY = 1;
	localparam int unsigned IRQ_LOST = 2;
	localparam int unsigned IRQ_GOOD = 3;

	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ccm_bus_t;

	typedef struct packed {
		logic start;
		logic valid;
		logic done;
		logic [5:0] idx;
		logic [7:0] data;
	} ccm_byte_in_t;

	typedef struct packed {
		logic [6:0] analog_cnt;
		logic [3:0] analog_in;
		logic [3:0] analog_out;
		logic [7:0] digital_in;
		logic [7:0] digital_out;
	} ccm_mod_t;

	typedef enum logic [1:0] {
		PH_WAIT_PRM,
		PH_WAIT_LAY,
		PH_RUN
	} ccm_phase_t;

	typedef logic [NTERM-1:0][1:0] ccm_map_t;

endpackage

// ### ccm_term_check.sv
/*
 * Compares the terminals that are plugged in with those that the
 * master expects. Purely combinational; the caller registers results.
 */
module ccm_term_check (
	// Expected configuration.
	input wire ccm_pkg::ccm_map_t enable_map_i,
	input wire logic [7:0] declared_cnt_i,
	// Physical terminals.
	input wire logic [ccm_pkg::NTERM-1:0] attached_i,
	// Result.
	output logic [ccm_pkg::NTERM-1:0] expected_o,
	output logic consistent_o
);

	// ==========================================================
	// Per-terminal expectation.
	genvar i;
	generate
		for (i = 0; i < ccm_pkg::NTERM; i++)
		begin : g_term
			// A declared terminal is expected unless coded disabled.
			assign expected_o[i] = (8'(i) < declared_cnt_i) &&
				(enable_map_i[i] != ccm_pkg::TERM_DISABLED);
		end
	endgenerate

	// The set must match bit for bit, reserves included.
	assign consistent_o = (expected_o == attached_i);

endmodule

// ### ccm_config_check.sv
/*
 * Parameter decoding and configuration consistency for a fieldbus
 * slave coupler. Assumes the parameter and layout byte streams, the
 * module summary and the attached-terminal map are synchronous to
 * core_clk_i, and that register strobes are one cycle long.
 */
module ccm_config_check (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Register port.
	input wire ccm_pkg::ccm_bus_t bus_i,
	output logic [ccm_pkg::DATA_W-1:0] rd_data_o,
	// Parameter and layout block streams from the master.
	input wire ccm_pkg::ccm_byte_in_t prm_i,
	input wire ccm_pkg::ccm_byte_in_t lay_i,
	// Attached modules.
	input wire ccm_pkg::ccm_mod_t mod_i,
	input wire logic [ccm_pkg::NTERM-1:0] attached_i,
	// Exchange control.
	output logic stat_diag_o,
	output logic data_exchange_o,
	output logic bus_cycle_en_o,
	output logic [ccm_pkg::LEN_W-1:0] in_len_o,
	output logic [ccm_pkg::LEN_W-1:0] out_len_o,
	output logic [ccm_pkg::LEN_W-1:0] dig_in_off_o,
	output logic [ccm_pkg::LEN_W-1:0] dig_out_off_o,
	// Interrupt.
	output logic irq_o
);

	// Local copies of the package widths, declared before any size cast.
	localparam int unsigned LEN_W = ccm_pkg::LEN_W;
	localparam int unsigned DATA_W = ccm_pkg::DATA_W;

	// ==========================================================
	// State.
	typedef struct packed {
		ccm_pkg::ccm_phase_t phase; // Load sequence.
		logic chk_off; // Layout check disabled.
		logic multi; // Multi-configuration mode.
		logic force_dx; // Exchange despite mismatch.
		logic cplx_global; // Global mapping choice.
		ccm_pkg::ccm_map_t map; // Terminal assignments.
		logic [ccm_pkg::LEN_W-1:0] lay_in; // Layout input bytes.
		logic [ccm_pkg::LEN_W-1:0] lay_out; // Layout output bytes.
		logic [7:0] declared; // Declared modules.
		logic consist; // Registered consistency.
		logic stat_diag;
		logic dx;
		logic bus_en;
		logic [ccm_pkg::LEN_W-1:0] in_len;
		logic [ccm_pkg::LEN_W-1:0] out_len;
		logic [ccm_pkg::LEN_W-1:0] din_off;
		logic [ccm_pkg::LEN_W-1:0] dout_off;
		logic [ccm_pkg::IRQ_W-1:0] irq_stat;
		logic [ccm_pkg::IRQ_W-1:0] irq_mask;
		logic ctrl_cplx; // Mapping used while checking.
		logic [ccm_pkg::DATA_W-1:0] rd_data;
		logic irq;
	} ccm_state_t;

	ccm_state_t s; // Registered state.
	ccm_state_t next_s; // Next state.

	// ==========================================================
	// Terminal comparison.
	logic term_ok; // Attached set matches expectation.
	logic [ccm_pkg::NTERM-1:0] expected; // Expected terminals.

	// The checker sees the map and count as currently registered.
	ccm_term_check u_term (
		.enable_map_i(s.map),
		.declared_cnt_i(s.declared),
		.attached_i(attached_i),
		.expected_o(expected),
		.consistent_o(term_ok)
	);

	// ==========================================================
	// Process image sizes.
	logic cplx_sel; // Mapping in force.
	logic [4:0] a_max; // Larger of analog in and out.
	logic [4:0] a_cplx; // Complex bytes per module.
	logic [ccm_pkg::LEN_W-1:0] an_in; // Analog input bytes.
	logic [ccm_pkg::LEN_W-1:0] an_out; // Analog output bytes.
	logic [ccm_pkg::LEN_W-1:0] need_in; // Input bytes modules need.
	logic [ccm_pkg::LEN_W-1:0] need_out; // Output bytes modules need.
	logic lay_ok; // Layout block accepted.
	logic consistent; // Whole configuration consistent.

	// Sizes follow from the mapping and the attached modules.
	always_comb
	begin
		// Without the check one global bit decides for all modules.
		cplx_sel = s.chk_off ? s.cplx_global : s.ctrl_cplx;
		a_max = (mod_i.analog_in > mod_i.analog_out) ?
			{1'b0, mod_i.analog_in} : {1'b0, mod_i.analog_out};
		a_cplx = a_max + ccm_pkg::CTL_BYTES;
		if (cplx_sel)
		begin
			// Complex: control bytes, same length both ways.
			an_in = LEN_W'(mod_i.analog_cnt) * a_cplx;
			an_out = an_in;
		end
		else
		begin
			// Compact: user data only.
			an_in = LEN_W'(mod_i.analog_cnt) * mod_i.analog_in;
			an_out = LEN_W'(mod_i.analog_cnt) * mod_i.analog_out;
		end
		need_in = an_in + LEN_W'(mod_i.digital_in);
		need_out = an_out + LEN_W'(mod_i.digital_out);
		// With the check off any layout block is accepted.
		lay_ok = s.chk_off ||
			((s.lay_in == need_in) && (s.lay_out == need_out));
		// Multi mode also needs the plugged terminals to match.
		consistent = lay_ok && (!s.multi || term_ok);
	end

	// ==========================================================
	// Next-state logic.
	always_comb
	begin
		logic [7:0] ident; // Layout identifier byte.
		logic [ccm_pkg::LEN_W-1:0] ilen; // Its data length.
		logic [6:0] tbase; // First terminal of a map byte.
		logic [ccm_pkg::IRQ_W-1:0] ev; // Events this cycle.
		logic [ccm_pkg::IRQ_W-1:0] clr; // Software clears.
		ident = lay_i.data;
		ilen = '0;
		tbase = '0;
		ev = '0;
		clr = '0;
		next_s = s;

		// Parameter block bytes are decoded as they arrive.
		if (prm_i.start)
		begin
			// A new block drops the running exchange.
			next_s.phase = ccm_pkg::PH_WAIT_PRM;
		end
		if (prm_i.valid)
		begin
			// Option bytes.
			if (prm_i.idx == ccm_pkg::PRM_CHK_BYTE)
			begin
				next_s.chk_off = prm_i.data[ccm_pkg::PRM_CHK_BIT];
			end
			if (prm_i.idx == ccm_pkg::PRM_MULTI_BYTE)
			begin
				next_s.multi = prm_i.data[ccm_pkg::PRM_MULTI_BIT];
				next_s.force_dx = prm_i.data[ccm_pkg::PRM_FORCE_BIT];
			end
			if (prm_i.idx == ccm_pkg::PRM_MAP_BYTE)
			begin
				next_s.cplx_global = prm_i.data[ccm_pkg::PRM_MAP_BIT];
			end
			// Map bytes: four terminals each, lowest in bits 1:0.
			if ((prm_i.idx >= ccm_pkg::PRM_LO_FIRST) &&
				(prm_i.idx <= ccm_pkg::PRM_LO_LAST))
			begin
				tbase = 7'({prm_i.idx - ccm_pkg::PRM_LO_FIRST, 2'b00});
				for (int k = 0; k < ccm_pkg::TERM_PER_BYTE; k++)
				begin
					next_s.map[tbase + 7'(k)] = prm_i.data[2*k +: 2];
				end
			end
			if ((prm_i.idx >= ccm_pkg::PRM_HI_FIRST) &&
				(prm_i.idx <= ccm_pkg::PRM_HI_LAST))
			begin
				tbase = ccm_pkg::TERM_HI_BASE +
					7'({prm_i.idx - ccm_pkg::PRM_HI_FIRST, 2'b00});
				for (int k = 0; k < ccm_pkg::TERM_PER_BYTE; k++)
				begin
					next_s.map[tbase + 7'(k)] = prm_i.data[2*k +: 2];
				end
			end
		end
		if (prm_i.done)
		begin
			// Block complete: wait for the layout block next.
			next_s.phase = ccm_pkg::PH_WAIT_LAY;
			ev[ccm_pkg::IRQ_PRM] = 1'b1;
		end

		// Layout block: sum input and output bytes, count modules.
		if (lay_i.start)
		begin
			next_s.lay_in = '0;
			next_s.lay_out = '0;
			next_s.declared = '0;
		end
		else if (lay_i.valid)
		begin
			ilen = LEN_W'(ident[ccm_pkg::LAY_LEN_LSB +: 4]) + 1'b1;
			if (ident[ccm_pkg::LAY_WORD_BIT])
			begin
				ilen = LEN_W'({ilen, 1'b0});
			end
			// Identifiers with no direction carry no data.
			if (ident[ccm_pkg::LAY_IN_BIT])
			begin
				next_s.lay_in = s.lay_in + ilen;
			end
			if (ident[ccm_pkg::LAY_OUT_BIT])
			begin
				next_s.lay_out = s.lay_out + ilen;
			end
			// Each identifier stands for one module in order.
			if (s.declared < 8'(ccm_pkg::NTERM))
			begin
				next_s.declared = s.declared + 8'h01;
			end
		end
		if (lay_i.done && (s.phase != ccm_pkg::PH_WAIT_PRM))
		begin
			next_s.phase = ccm_pkg::PH_RUN;
			ev[ccm_pkg::IRQ_LAY] = 1'b1;
		end

		// Exchange state, evaluated every cycle.
		case (s.phase)
			ccm_pkg::PH_RUN:
			begin
				next_s.consist = consistent;
				next_s.stat_diag = !consistent;
				// The force bit only relaxes multi mode.
				next_s.dx = consistent ||
					(s.multi && s.force_dx);
				next_s.bus_en = consistent;
				if (s.consist && !consistent)
				begin
					ev[ccm_pkg::IRQ_LOST] = 1'b1;
				end
				if (!s.consist && consistent)
				begin
					ev[ccm_pkg::IRQ_GOOD] = 1'b1;
				end
			end
			default:
			begin
				// Not parameterised yet: no exchange.
				next_s.consist = 1'b0;
				next_s.stat_diag = 1'b1;
				next_s.dx = 1'b0;
				next_s.bus_en = 1'b0;
			end
		endcase

		// Lengths follow the layout block when unchecked.
		next_s.in_len = s.chk_off ? s.lay_in : need_in;
		next_s.out_len = s.chk_off ? s.lay_out : need_out;
		// Digital data sits behind all analog data.
		next_s.din_off = an_in;
		next_s.dout_off = an_out;

		// Register writes.
		if (bus_i.wr)
		begin
			case (bus_i.addr)
				ccm_pkg::REG_IRQ_STAT:
				begin
					clr = bus_i.wdata[ccm_pkg::IRQ_W-1:0];
				end
				ccm_pkg::REG_IRQ_MASK:
				begin
					next_s.irq_mask = bus_i.wdata[ccm_pkg::IRQ_W-1:0];
				end
				ccm_pkg::REG_CTRL:
				begin
					next_s.ctrl_cplx = bus_i.wdata[ccm_pkg::CTRL_CPLX_BIT];
				end
				default:
				begin
					// Read-only and unmapped words ignore writes.
				end
			endcase
		end

		// A new event wins over a clear in the same cycle.
		next_s.irq_stat = (s.irq_stat & ~clr) | ev;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

		// Register reads answer in the next cycle only.
		next_s.rd_data = '0;
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				ccm_pkg::REG_STATUS:
				begin
					next_s.rd_data = DATA_W'({s.cplx_global, s.force_dx,
						s.chk_off, s.multi, s.bus_en, s.dx,
						s.stat_diag, s.consist});
				end
				ccm_pkg::REG_IRQ_STAT:
				begin
					next_s.rd_data = DATA_W'(s.irq_stat);
				end
				ccm_pkg::REG_IRQ_MASK:
				begin
					next_s.rd_data = DATA_W'(s.irq_mask);
				end
				ccm_pkg::REG_CTRL:
				begin
					next_s.rd_data = DATA_W'(s.ctrl_cplx);
				end
				ccm_pkg::REG_IN_LEN:
				begin
					next_s.rd_data = DATA_W'(s.in_len);
				end
				ccm_pkg::REG_OUT_LEN:
				begin
					next_s.rd_data = DATA_W'(s.out_len);
				end
				ccm_pkg::REG_DIG_OFF:
				begin
					next_s.rd_data = DATA_W'(s.declared);
				end
				default:
				begin
					// Unmapped words read as zero.
					next_s.rd_data = '0;
				end
			endcase
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			// All terminals enabled, no exchange, diagnosis pending.
			s <= '0;
			s.stat_diag <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs, each taken straight from the state register.
	assign rd_data_o = s.rd_data;
	assign stat_diag_o = s.stat_diag;
	assign data_exchange_o = s.dx;
	assign bus_cycle_en_o = s.bus_en;
	assign in_len_o = s.in_len;
	assign out_len_o = s.out_len;
	assign dig_in_off_o = s.din_off;
	assign dig_out_off_o = s.dout_off;
	assign irq_o = s.irq;

endmodule

// ### ccm_cfg_monitor.sv
/*
 * Port checker for the configuration checker, bound to its top module.
 * Assumes one clock and a synchronous active-high reset.
 */
module ccm_cfg_monitor (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Observed inputs.
	input wire ccm_pkg::ccm_bus_t bus_i,
	input wire ccm_pkg::ccm_byte_in_t prm_i,
	// Observed outputs.
	input wire logic [15:0] rd_data_o,
	input wire logic stat_diag_o,
	input wire logic data_exchange_o,
	input wire logic bus_cycle_en_o,
	input wire logic [11:0] in_len_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	// ==========================================================
	// Properties.
	// Reset leaves the coupler diagnosed and without exchange.
	property p_rst_vals;
		disable iff (1'b0) sys_rst_i |=> stat_diag_o && !data_exchange_o
			&& !bus_cycle_en_o && !irq_o;
	endproperty
	property p_diag_bus;
		bus_cycle_en_o |-> !stat_diag_o;
	endproperty
	property p_bus_dx;
		bus_cycle_en_o |-> data_exchange_o;
	endproperty
	// Exchange without bus cycles only while diagnosed.
	property p_force;
		data_exchange_o && !bus_cycle_en_o |-> stat_diag_o;
	endproperty
	property p_rd_idle;
		!bus_i.rd |=> rd_data_o == 16'h0000;
	endproperty
	property p_unmapped;
		bus_i.rd && bus_i.addr > 4'h6 |=> rd_data_o == 16'h0000;
	endproperty
	property p_len_rd;
		bus_i.rd && bus_i.addr == ccm_pkg::REG_IN_LEN
			|=> rd_data_o == {4'h0, $past(in_len_o)};
	endproperty
	property p_mask_off;
		bus_i.wr && bus_i.addr == ccm_pkg::REG_IRQ_MASK
			&& bus_i.wdata == 16'h0000 |-> ##[2:3] !irq_o;
	endproperty
	property p_prm_drop;
		prm_i.start |-> ##[1:3] !data_exchange_o;
	endproperty

	// ==========================================================
	// Assertions and covers.
	a_rst_vals: assert property (p_rst_vals)
		else $error("reset values wrong");
	a_diag_bus: assert property (p_diag_bus)
		else $error("bus cycles while diagnosed");
	a_bus_dx: assert property (p_bus_dx)
		else $error("bus cycles without exchange");
	a_force: assert property (p_force)
		else $error("exchange without cycles but no diagnosis");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_len_rd: assert property (p_len_rd)
		else $error("input length read wrong");
	a_mask_off: assert property (p_mask_off)
		else $error("masked interrupt still high");
	a_prm_drop: assert property (p_prm_drop)
		else $error("exchange kept over new parameters");
	c_force: cover property (data_exchange_o && stat_diag_o);
	c_run: cover property (bus_cycle_en_o);
	c_irq: cover property (irq_o);
endmodule

bind ccm_config_check ccm_cfg_monitor u_mon (
	.core_clk_i(core_clk_i),
	.sys_rst_i(sys_rst_i),
	.bus_i(bus_i),
	.prm_i(prm_i),
	.rd_data_o(rd_data_o),
	.stat_diag_o(stat_diag_o),
	.data_exchange_o(data_exchange_o),
	.bus_cycle_en_o(bus_cycle_en_o),
	.in_len_o(in_len_o),
	.irq_o(irq_o)
);

// ### ccm_master_model.sv
/*
 * Fieldbus master model: streams the user parameter block and then the
 * slave layout block. Assumes the coupler samples on core_clk_i.
 */
module ccm_master_model (
	// Clock.
	input wire logic core_clk_i,
	// Byte streams to the coupler.
	output ccm_pkg::ccm_byte_in_t prm_o,
	output ccm_pkg::ccm_byte_in_t lay_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] prm_img [0:56]; // Parameter bytes, set by the bench.
	logic [7:0] lay_img [0:127]; // Layout identifiers, set by the bench.
	int lay_n = 0; // Number of identifiers sent.
	logic [13:0] junk = 14'h2a5c; // Idle pattern, so no stale byte shows.

	initial
	begin
		prm_o = '0;
		lay_o = '0;
	end

	// Drives one word on one stream; the other idles with junk.
	task automatic put(input bit sel, input logic [2:0] ctl,
		input logic [5:0] ix, input logic [7:0] dt);
		ccm_pkg::ccm_byte_in_t w;
		@(posedge core_clk_i);
		w = ctl[1] ? {ctl, ix, dt} : {ctl, junk};
		junk <= ~junk;
		prm_o <= sel ? {3'b000, junk} : w;
		lay_o <= sel ? w : {3'b000, junk};
	endtask

	// Sends the parameter block, then the layout block.
	task automatic send_all;
		int i;
		put(1'b0, 3'b100, 6'h00, 8'h00);
		for (i = 0; i < 57; i++)
			put(1'b0, 3'b010, 6'(i), prm_img[i]);
		put(1'b0, 3'b001, 6'h00, 8'h00);
		put(1'b1, 3'b100, 6'h00, 8'h00);
		// One identifier per declared module, reserves included.
		for (i = 0; i < lay_n; i++)
			put(1'b1, 3'b010, 6'h00, lay_img[i]);
		put(1'b1, 3'b001, 6'h00, 8'h00);
		put(1'b1, 3'b000, 6'h00, 8'h00);
	endtask
endmodule

// ### tb_top.sv
/*
 * Self-checking bench for the configuration checker.
 * Assumes the master model and the bound checker are compiled first.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Signals.
	logic core_clk_i;
	logic sys_rst_i;
	ccm_pkg::ccm_bus_t bus_i;
	ccm_pkg::ccm_byte_in_t prm_i;
	ccm_pkg::ccm_byte_in_t lay_i;
	ccm_pkg::ccm_mod_t mod_i;
	logic [127:0] attached_i;
	logic [15:0] rd_data_o;
	logic stat_diag_o, data_exchange_o, bus_cycle_en_o, irq_o;
	logic [11:0] in_len_o, out_len_o, dig_in_off_o, dig_out_off_o;
	int bad_count = 0;
	int n_checks = 0;
	logic [15:0] d;

	ccm_config_check uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.bus_i(bus_i), .rd_data_o(rd_data_o), .prm_i(prm_i),
		.lay_i(lay_i), .mod_i(mod_i), .attached_i(attached_i),
		.stat_diag_o(stat_diag_o), .data_exchange_o(data_exchange_o),
		.bus_cycle_en_o(bus_cycle_en_o), .in_len_o(in_len_o),
		.out_len_o(out_len_o), .dig_in_off_o(dig_in_off_o),
		.dig_out_off_o(dig_out_off_o), .irq_o(irq_o));
	ccm_master_model m (.core_clk_i(core_clk_i), .prm_o(prm_i),
		.lay_o(lay_i));

	// Clock at 200 MHz.
	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// ==========================================================
	// Tasks.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk_i);
		bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge core_clk_i);
		bus_i.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge core_clk_i);
		bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge core_clk_i);
		bus_i.rd <= 1'b0;
		#1 v = rd_data_o;
	endtask
	// Sets the layout: first identifier a, all the rest b.
	task automatic lay(input int n, input logic [7:0] a, input logic [7:0] b);
		int i;
		m.lay_n = n;
		for (i = 0; i < n; i++)
			m.lay_img[i] = (i == 0) ? a : b;
	endtask
	task automatic cfg;
		m.send_all();
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	task automatic settle;
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	// Flags are {diagnosis, exchange, bus cycles}.
	task automatic expo(input logic [2:0] f, input logic [11:0] il,
		input logic [11:0] ol, input logic [11:0] di, input logic [11:0] dv);
		chk({13'h0, stat_diag_o, data_exchange_o, bus_cycle_en_o}, {13'h0, f});
		chk({4'h0, in_len_o}, {4'h0, il});
		chk({4'h0, out_len_o}, {4'h0, ol});
		chk({4'h0, dig_in_off_o}, {4'h0, di});
		chk({4'h0, dig_out_off_o}, {4'h0, dv});
	endtask
	task automatic stop_test;
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog against a hang.
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		bad_count++;
		stop_test();
	end

	// ==========================================================
	// Test sequence.
	initial
	begin
		int i;
		sys_rst_i = 1'b1;
		bus_i = '0;
		attached_i = 128'h0;
		mod_i = '{analog_cnt: 7'h02, analog_in: 4'h2, analog_out: 4'h1,
			digital_in: 8'h01, digital_out: 8'h01};
		for (i = 0; i < 57; i++)
			m.prm_img[i] = 8'h00;
		repeat (6) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk({15'h0, stat_diag_o}, 16'h0001);
		lay(2, 8'h14, 8'h22);
		cfg();
		expo(3'b011, 12'h005, 12'h003, 12'h004, 12'h002);
		rd(ccm_pkg::REG_OUT_LEN, d);
		chk(d, 16'h0003);
		// Register port and interrupt.
		rd(ccm_pkg::REG_IN_LEN, d);
		chk(d, 16'h0005);
		wr(ccm_pkg::REG_IN_LEN, 16'h0fff);
		rd(ccm_pkg::REG_IN_LEN, d);
		chk(d, 16'h0005);
		rd(4'hf, d);
		chk(d, 16'h0000);
		rd(ccm_pkg::REG_IRQ_STAT, d);
		chk(d & 16'h0003, 16'h0003);
		chk({15'h0, irq_o}, 16'h0000);
		wr(ccm_pkg::REG_IRQ_MASK, 16'h0001);
		rd(ccm_pkg::REG_IRQ_MASK, d);
		chk(d, 16'h0001);
		settle();
		chk({15'h0, irq_o}, 16'h0001);
		wr(ccm_pkg::REG_IRQ_STAT, 16'h000f);
		settle();
		chk({15'h0, irq_o}, 16'h0000);
		wr(ccm_pkg::REG_IRQ_MASK, 16'h0000);
		// Complex mapping, then a mismatching layout refused.
		wr(ccm_pkg::REG_CTRL, 16'h0001);
		rd(ccm_pkg::REG_CTRL, d);
		chk(d, 16'h0001);
		lay(2, 8'h16, 8'h26);
		cfg();
		expo(3'b011, 12'h007, 12'h007, 12'h006, 12'h006);
		lay(2, 8'h14, 8'h22);
		cfg();
		expo(3'b100, 12'h007, 12'h007, 12'h006, 12'h006);
		// Check off with the global complex mapping bit.
		wr(ccm_pkg::REG_CTRL, 16'h0000);
		m.prm_img[1] = 8'h01;
		m.prm_img[9] = 8'h04;
		lay(3, 8'h1f, 8'h2f);
		cfg();
		expo(3'b011, 12'h010, 12'h020, 12'h006, 12'h006);
		// Multi-configuration: terminals 63 and 65 disabled.
		m.prm_img[9] = 8'h00;
		m.prm_img[3] = 8'h10;
		m.prm_img[30] = 8'h80;
		m.prm_img[41] = 8'h08;
		lay(66, 8'h10, 8'h10);
		@(posedge core_clk_i);
		attached_i <= 128'h1_7fff_ffff_ffff_ffff;
		cfg();
		expo(3'b011, 12'h042, 12'h000, 12'h004, 12'h002);
		// Clear old events so that the loss below must set its own bit.
		wr(ccm_pkg::REG_IRQ_STAT, 16'h000f);
		rd(ccm_pkg::REG_IRQ_STAT, d);
		chk(d, 16'h0000);
		rd(ccm_pkg::REG_DIG_OFF, d);
		chk(d, 16'h0042);
		@(posedge core_clk_i);
		attached_i[65] <= 1'b1;
		settle();
		expo(3'b100, 12'h042, 12'h000, 12'h004, 12'h002);
		rd(ccm_pkg::REG_IRQ_STAT, d);
		chk(d, 16'h0004);
		m.prm_img[3] = 8'h50;
		cfg();
		expo(3'b110, 12'h042, 12'h000, 12'h004, 12'h002);
		rd(ccm_pkg::REG_STATUS, d);
		chk(d, 16'h0076);
		@(posedge core_clk_i);
		attached_i[65] <= 1'b0;
		settle();
		expo(3'b011, 12'h042, 12'h000, 12'h004, 12'h002);
		stop_test();
	end
endmodule
